// >>> hdl/ebt_defines.svh
// Constants for the external bus timing engine
`ifndef EBT_DEFINES_SVH
`define EBT_DEFINES_SVH
`define EBT_RAM_REMAP_BASE 32'h0030_0000
`define EBT_BOOT_BASE 32'h0000_0000
`define EBT_NUM_CS 8
`define EBT_CS_W 3
`define EBT_NWS_W 3
`define EBT_TDF_W 3
`define EBT_CNT_W 4
`define EBT_DBW_16 2'h1
`define EBT_DBW_8 2'h2
`define EBT_BOOT_CS 3'h0
`endif

// >>> hdl/ebt_pkg.sv
// Types for the external bus timing engine
package ebt_pkg;
  typedef enum logic [2:0] {
    EBT_IDLE = 3'b000,
    EBT_GAP = 3'b001,
    EBT_ACC = 3'b010,
    EBT_WAIT = 3'b011,
    EBT_END = 3'b100
  } ebt_state_t;
endpackage

// >>> hdl/ebt_cs_cfg.sv
// Per chip select timing configuration store
`timescale 1ns/10ps
`default_nettype none
module ebt_cs_cfg
  import ebt_pkg::*;
#(
  parameter int NUM_CS = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_cfg_we,
  input wire logic [2:0] i_cfg_sel,
  input wire logic i_cfg_wse,
  input wire logic [2:0] i_cfg_nws,
  input wire logic [2:0] i_cfg_tdf,
  input wire logic i_cfg_bat,
  input wire logic [1:0] i_cfg_dbw,
  input wire logic [2:0] i_rd_sel,
  output logic o_rd_wse,
  output logic [2:0] o_rd_nws,
  output logic [2:0] o_rd_tdf,
  output logic o_rd_bat,
  output logic [1:0] o_rd_dbw
);
  logic [9:0] mem_ff [NUM_CS];
  logic [9:0] nxt_mem [NUM_CS];
  logic [9:0] rd_ff;
  logic [9:0] nxt_rd;
  logic [9:0] wr_word;

  assign wr_word = {i_cfg_wse, i_cfg_nws, i_cfg_tdf, i_cfg_bat, i_cfg_dbw};

  // Bypass so a fresh write is seen on the very next access
  always_comb begin
    for (int k = 0; k < NUM_CS; k++) begin
      nxt_mem[k] = mem_ff[k];
    end
    if (i_cfg_we) begin
      nxt_mem[i_cfg_sel] = wr_word;
    end
    nxt_rd = nxt_mem[i_rd_sel];
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      // Reset state of every select: 8-bit bus, no waits
      for (int k = 0; k < NUM_CS; k++) begin
        mem_ff[k] <= 10'h002;
      end
      rd_ff <= 10'h002;
    end else begin
      for (int k = 0; k < NUM_CS; k++) begin
        mem_ff[k] <= nxt_mem[k];
      end
      rd_ff <= nxt_rd;
    end
  end

  assign {o_rd_wse, o_rd_nws, o_rd_tdf, o_rd_bat, o_rd_dbw} = rd_ff;
endmodule // ebt_cs_cfg
`default_nettype wire

// >>> hdl/ebt_bus_engine.sv
// External bus access engine: strobes, waits, boot remap
`include "ebt_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module ebt_bus_engine
  import ebt_pkg::*;
#(
  parameter int NUM_CS = `EBT_NUM_CS,
  parameter int ADDR_W = 24
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_pin_reset_n,
  input wire logic i_boot_memory_pin,
  input wire logic i_remap_cancel_bit,
  input wire logic i_read_protocol_field,
  input wire logic i_cfg_we,
  input wire logic [2:0] i_cfg_sel,
  input wire logic i_wait_state_enable_field,
  input wire logic [2:0] i_wait_state_count_field,
  input wire logic [2:0] i_data_float_time_field,
  input wire logic i_byte_access_type_field,
  input wire logic [1:0] i_cfg_dbw,
  input wire logic i_req,
  input wire logic i_req_ext,
  input wire logic i_req_write,
  input wire logic [2:0] i_req_cs,
  input wire logic [ADDR_W-1:0] i_req_addr,
  input wire logic [1:0] i_req_byte_en,
  input wire logic [15:0] i_req_wdata,
  input wire logic i_external_wait_request_n,
  output logic o_req_ready,
  output logic o_done,
  output logic o_remap_active,
  output logic o_boot_8bit,
  output logic [31:0] o_ram_base,
  output logic [ADDR_W-1:0] o_addr,
  output logic [NUM_CS-1:0] o_chip_select_n,
  output logic o_read_strobe_n,
  output logic o_lower_byte_write_strobe_n,
  output logic o_upper_byte_write_strobe_n,
  output logic o_lower_byte_select_n,
  output logic o_upper_byte_select_n,
  output logic [15:0] o_data_out,
  output logic o_data_oe
);
  // ------------------------------------------------------------
  // Boot selection and remap
  // ------------------------------------------------------------
  logic boot_8bit_ff, nxt_boot_8bit;
  logic pin_rst_q_ff, nxt_pin_rst_q;
  logic remap_ff, nxt_remap;

  // Boot strap caught while pin reset is low; a watchdog reset on
  // i_resetn alone leaves the strap register alone
  always_comb begin
    nxt_pin_rst_q = i_pin_reset_n;
    nxt_boot_8bit = boot_8bit_ff;
    if (!i_pin_reset_n) begin
      nxt_boot_8bit = i_boot_memory_pin;
    end
    nxt_remap = remap_ff;
    if (i_remap_cancel_bit) begin
      nxt_remap = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    boot_8bit_ff <= nxt_boot_8bit;
    pin_rst_q_ff <= nxt_pin_rst_q;
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      remap_ff <= 1'b1;
    end else begin
      remap_ff <= nxt_remap;
    end
  end

  assign o_remap_active = remap_ff;
  assign o_boot_8bit = boot_8bit_ff;
  assign o_ram_base = remap_ff ? `EBT_RAM_REMAP_BASE : `EBT_BOOT_BASE;

  // ------------------------------------------------------------
  // Configuration store
  // ------------------------------------------------------------
  logic cfg_wse, cfg_bat;
  logic [2:0] cfg_nws, cfg_tdf;
  logic [1:0] cfg_dbw;
  logic [2:0] eff_cs;
  logic [2:0] cfg_rd_cs;

  // Remap forces every external access onto the boot select
  assign eff_cs = remap_ff ? `EBT_BOOT_CS : i_req_cs;

  // Writes bypass into the read port: wait changes act at once
  ebt_cs_cfg #(.NUM_CS(NUM_CS)) u_cfg (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_cfg_we(i_cfg_we),
    .i_cfg_sel(i_cfg_sel),
    .i_cfg_wse(i_wait_state_enable_field),
    .i_cfg_nws(i_wait_state_count_field),
    .i_cfg_tdf(i_data_float_time_field),
    .i_cfg_bat(i_byte_access_type_field),
    .i_cfg_dbw(i_cfg_dbw),
    .i_rd_sel(cfg_rd_cs),
    .o_rd_wse(cfg_wse),
    .o_rd_nws(cfg_nws),
    .o_rd_tdf(cfg_tdf),
    .o_rd_bat(cfg_bat),
    .o_rd_dbw(cfg_dbw)
  );

  // ------------------------------------------------------------
  // Access sequencer
  // ------------------------------------------------------------
  ebt_state_t state_ff, nxt_state;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [2:0] float_ff, nxt_float;
  logic [2:0] float_cs_ff, nxt_float_cs;
  logic [2:0] cur_cs_ff, nxt_cur_cs;
  logic [2:0] last_cs_ff, nxt_last_cs;
  logic last_valid_ff, nxt_last_valid;
  logic last_write_ff, nxt_last_write;
  logic wr_ff, nxt_wr;
  logic early_ff, nxt_early;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic [1:0] ben_ff, nxt_ben;
  logic [15:0] wdata_ff, nxt_wdata;
  logic rd_hold_ff, nxt_rd_hold;
  logic [3:0] gap;
  logic hold;

  // Once taken, timing follows the select in flight, not the request bus
  assign cfg_rd_cs = (state_ff == EBT_IDLE) ? eff_cs : cur_cs_ff;

  assign hold = !i_external_wait_request_n;

  function automatic logic [3:0] wait_cycles(input logic wait_state_enable_field,
                                             input logic [2:0] wait_state_count_field);
    wait_cycles = wait_state_enable_field ? ({1'b0, wait_state_count_field} + 4'h1) : 4'h0;
  endfunction

  // Gap cycles ahead of an external access from prior traffic
  always_comb begin
    gap = 4'h0;
    if (last_valid_ff && !last_write_ff && float_ff != 3'h0 &&
        (i_req_write || float_cs_ff != eff_cs)) begin
      gap = {1'b0, float_ff};
    end
    if (last_valid_ff && last_write_ff && !i_req_write &&
        i_read_protocol_field) begin
      gap = gap + 4'h1;
    end
    if (gap == 4'h0 && last_valid_ff && last_cs_ff != eff_cs) begin
      gap = 4'h1;
    end
  end

  assign o_req_ready = (state_ff == EBT_IDLE) && !hold;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_float = float_ff;
    nxt_float_cs = float_cs_ff;
    nxt_cur_cs = cur_cs_ff;
    nxt_last_cs = last_cs_ff;
    nxt_last_valid = last_valid_ff;
    nxt_last_write = last_write_ff;
    nxt_wr = wr_ff;
    nxt_early = early_ff;
    nxt_addr = addr_ff;
    nxt_ben = ben_ff;
    nxt_wdata = wdata_ff;
    nxt_rd_hold = 1'b0;
    if (!hold) begin
      // Float time runs down regardless of internal traffic
      if (float_ff != 3'h0 && state_ff != EBT_ACC && state_ff != EBT_WAIT) begin
        nxt_float = float_ff - 3'h1;
      end
      case (state_ff)
        EBT_IDLE: begin
          if (i_req && i_req_ext) begin
            nxt_cur_cs = eff_cs;
            nxt_wr = i_req_write;
            nxt_early = i_read_protocol_field;
            nxt_addr = i_req_addr;
            nxt_ben = i_req_byte_en;
            nxt_wdata = i_req_wdata;
            nxt_cnt = gap;
            nxt_state = (gap != 4'h0) ? EBT_GAP : EBT_ACC;
          end
        end
        EBT_GAP: begin
          nxt_cnt = cnt_ff - 4'h1;
          if (cnt_ff == 4'h1) begin
            nxt_state = EBT_ACC;
          end
        end
        EBT_ACC: begin
          nxt_cnt = wait_cycles(cfg_wse, cfg_nws);
          nxt_state = (nxt_cnt != 4'h0) ? EBT_WAIT : EBT_END;
        end
        EBT_WAIT: begin
          nxt_cnt = cnt_ff - 4'h1;
          if (cnt_ff == 4'h1) begin
            nxt_state = EBT_END;
          end
        end
        EBT_END: begin
          nxt_last_valid = 1'b1;
          nxt_last_cs = cur_cs_ff;
          nxt_last_write = wr_ff;
          if (!wr_ff) begin
            nxt_float = cfg_tdf;
            nxt_float_cs = cur_cs_ff;
          end
          // Early read keeps the strobe up into a same-memory read
          nxt_rd_hold = early_ff && !wr_ff && i_req && i_req_ext &&
                        !i_req_write && eff_cs == cur_cs_ff;
          nxt_state = EBT_IDLE;
        end
        default: nxt_state = EBT_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state_ff <= EBT_IDLE;
      cnt_ff <= 4'h0;
      float_ff <= 3'h0;
      float_cs_ff <= 3'h0;
      cur_cs_ff <= 3'h0;
      last_cs_ff <= 3'h0;
      last_valid_ff <= 1'b0;
      last_write_ff <= 1'b0;
      wr_ff <= 1'b0;
      early_ff <= 1'b0;
      addr_ff <= '0;
      ben_ff <= 2'h0;
      wdata_ff <= 16'h0000;
      rd_hold_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      float_ff <= nxt_float;
      float_cs_ff <= nxt_float_cs;
      cur_cs_ff <= nxt_cur_cs;
      last_cs_ff <= nxt_last_cs;
      last_valid_ff <= nxt_last_valid;
      last_write_ff <= nxt_last_write;
      wr_ff <= nxt_wr;
      early_ff <= nxt_early;
      addr_ff <= nxt_addr;
      ben_ff <= nxt_ben;
      wdata_ff <= nxt_wdata;
      rd_hold_ff <= nxt_rd_hold;
    end
  end

  assign o_done = (state_ff == EBT_END) && !hold;

  // ------------------------------------------------------------
  // Pin timing
  // ------------------------------------------------------------
  // Second-half strobes come from the falling edge; the late flops decode
  // state_ff and cnt_ff, which hold during a wait request, so a frozen cycle stays frozen
  logic active;
  logic rd_early, rd_late_ff, wr_late_ff;
  logic wr_on;
  logic data_oe_ff;
  logic [15:0] dout_ff;
  logic bsel;

  assign active = (state_ff == EBT_ACC) || (state_ff == EBT_WAIT) ||
                  (state_ff == EBT_END);

  always_ff @(negedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_late_ff <= 1'b0;
      wr_late_ff <= 1'b0;
    end else begin
      rd_late_ff <= active && !wr_ff;
      wr_late_ff <= wr_ff && (state_ff == EBT_ACC ||
                    (state_ff == EBT_WAIT && cnt_ff != 4'h1));
    end
  end

  assign rd_early = (active && !wr_ff && early_ff) || rd_hold_ff;

  // Zero waits: strobe ends at the rising edge, half a cycle low
  assign wr_on = wr_late_ff &&
                 (state_ff == EBT_ACC || state_ff == EBT_WAIT);

  // Data enable opens with the late write flop, as the strobe falls, and holds past the strobe's rising edge
  always_comb begin
    data_oe_ff = 1'b0;
  end
  logic oe_q_ff;
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      oe_q_ff <= 1'b0;
      dout_ff <= 16'h0000;
    end else begin
      oe_q_ff <= wr_late_ff || (oe_q_ff && hold);
      dout_ff <= wdata_ff;
    end
  end

  assign bsel = cfg_bat && cfg_dbw == `EBT_DBW_16;
  assign o_addr = addr_ff;
  assign o_data_out = dout_ff;
  assign o_data_oe = wr_late_ff || oe_q_ff || data_oe_ff;

  always_comb begin
    o_chip_select_n = '1;
    if (active) begin
      o_chip_select_n[cur_cs_ff] = 1'b0;
    end
    o_read_strobe_n = !(rd_early || (rd_late_ff && active));
    o_lower_byte_write_strobe_n = 1'b1;
    o_upper_byte_write_strobe_n = 1'b1;
    o_lower_byte_select_n = addr_ff[0];
    o_upper_byte_select_n = 1'b1;
    if (bsel) begin
      o_lower_byte_write_strobe_n = !wr_on;
      o_lower_byte_select_n = !(active && ben_ff[0]);
      o_upper_byte_select_n = !(active && ben_ff[1]);
    end else begin
      o_lower_byte_write_strobe_n = !(wr_on && ben_ff[0]);
      o_upper_byte_write_strobe_n = !(wr_on && ben_ff[1]);
    end
  end
endmodule // ebt_bus_engine
`default_nettype wire

// >>> tb/ebt_engine_checker.sv
// Port assertions for the external bus engine
`timescale 1ns/10ps
`default_nettype none
module ebt_engine_checker #(
  parameter int NUM_CS = 8,
  parameter int ADDR_W = 24
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_remap_cancel_bit,
  input wire logic i_read_protocol_field,
  input wire logic i_external_wait_request_n,
  input wire logic o_req_ready,
  input wire logic o_remap_active,
  input wire logic [31:0] o_ram_base,
  input wire logic [ADDR_W-1:0] o_addr,
  input wire logic [NUM_CS-1:0] o_chip_select_n,
  input wire logic o_read_strobe_n,
  input wire logic o_lower_byte_write_strobe_n,
  input wire logic o_upper_byte_write_strobe_n,
  input wire logic o_data_oe
);
  logic wr_n;
  logic wr_ff;
  logic rd_ff;
  assign wr_n = o_lower_byte_write_strobe_n & o_upper_byte_write_strobe_n;
  // Second-half level, compared in the following first half
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_ff <= 1'h1;
      rd_ff <= 1'h1;
    end else begin
      wr_ff <= wr_n;
      rd_ff <= o_read_strobe_n;
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  property p_idle; o_req_ready |-> wr_n; endproperty
  a_idle: assert property (p_idle)
    else $error("write strobe low while idle");
  property p_base; o_remap_active |-> o_ram_base == 32'h0030_0000; endproperty
  a_base: assert property (p_base)
    else $error("ram base wrong during remap");
  property p_cancel; i_remap_cancel_bit |=> !o_remap_active; endproperty
  a_cancel: assert property (p_cancel)
    else $error("remap not cancelled");
  property p_stay; !o_remap_active |=> !o_remap_active; endproperty
  a_stay: assert property (p_stay)
    else $error("remap came back");
  property p_boot; o_remap_active |-> &o_chip_select_n[NUM_CS-1:1]; endproperty
  a_boot: assert property (p_boot)
    else $error("non-boot select active during remap");
  property p_freeze;
    !i_external_wait_request_n && !o_req_ready |=>
      $stable(o_addr) && $stable(o_chip_select_n);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("outputs moved during wait request");
  property p_wr_half; @(negedge i_clk_sys) !wr_n |-> !wr_ff; endproperty
  a_wr_half: assert property (p_wr_half)
    else $error("write strobe fell in first half");
  property p_rd_half;
    @(negedge i_clk_sys) !i_read_protocol_field && !o_read_strobe_n |-> !rd_ff;
  endproperty
  a_rd_half: assert property (p_rd_half)
    else $error("standard read strobe fell early");
  property p_drive; !wr_n |-> o_data_oe; endproperty
  a_drive: assert property (p_drive)
    else $error("data not driven under write strobe");
endmodule // ebt_engine_checker
bind ebt_bus_engine ebt_engine_checker #(.NUM_CS(NUM_CS), .ADDR_W(ADDR_W))
  u_chk (.i_clk_sys, .i_resetn, .i_remap_cancel_bit, .i_read_protocol_field,
  .i_external_wait_request_n, .o_req_ready, .o_remap_active, .o_ram_base,
  .o_addr, .o_chip_select_n, .o_read_strobe_n, .o_lower_byte_write_strobe_n,
  .o_upper_byte_write_strobe_n, .o_data_oe);
`default_nettype wire

// >>> tb/ebt_mem_model.sv
// Behavioural external memory watching the bus strobes
`timescale 1ns/10ps
`default_nettype none
module ebt_mem_model (
  input wire logic i_clk_sys,
  input wire logic i_clr,
  input wire logic [3:0] i_stall,
  input wire logic [7:0] i_cs_n,
  input wire logic i_rd_n,
  input wire logic i_lw_n,
  input wire logic i_uw_n,
  input wire logic i_lb_n,
  input wire logic i_ub_n,
  input wire logic [15:0] i_data,
  input wire logic i_oe,
  output logic o_wait_n,
  output logic [4:0] o_seen,
  output logic [15:0] o_wdata,
  output int o_wr_width,
  output int o_rd_phase
);
  logic [3:0] cnt = 4'h0;
  logic idle_q = 1'h1;
  realtime t_fall = 0.0;
  assign o_wait_n = (cnt == 4'h0);
  always @(posedge i_clr) o_seen = 5'h00;
  always @(negedge i_rd_n) begin
    o_seen[4] = 1'h1;
    o_rd_phase = int'($realtime * 10) % 250;
  end
  always @(negedge i_lw_n) o_seen[3] = 1'h1;
  always @(negedge i_uw_n) o_seen[2] = 1'h1;
  always @(negedge i_lb_n) o_seen[1] = 1'h1;
  always @(negedge i_ub_n) o_seen[0] = 1'h1;
  always @(negedge (i_lw_n & i_uw_n)) t_fall = $realtime;
  // Undriven data shows inverted so a late sample cannot match
  always @(posedge (i_lw_n & i_uw_n)) begin
    o_wr_width = int'(($realtime - t_fall) * 10);
    o_wdata = i_oe ? i_data : ~i_data;
  end
  // Wait held low for a commanded count on a fresh select
  always @(posedge i_clk_sys) begin
    idle_q <= &i_cs_n;
    if (idle_q && !(&i_cs_n) && i_stall != 4'h0) cnt <= i_stall;
    else if (cnt != 4'h0) cnt <= cnt - 4'h1;
  end
endmodule // ebt_mem_model
`default_nettype wire

// >>> tb/ebt_bus_engine_test.sv
// Self-checking bench for the external bus engine
`timescale 1ns/10ps
`default_nettype none
module ebt_bus_engine_test
  import ebt_pkg::*;
;
  logic i_clk_sys = 0, i_resetn = 0, i_pin_reset_n = 0, i_boot_memory_pin = 1;
  logic i_remap_cancel_bit = 0, i_read_protocol_field = 0, i_cfg_we = 0;
  logic [2:0] i_cfg_sel = 0, i_wait_state_count_field = 0, i_req_cs = 0;
  logic [2:0] i_data_float_time_field = 0;
  logic i_wait_state_enable_field = 0, i_byte_access_type_field = 0;
  logic [1:0] i_cfg_dbw = 0, i_req_byte_en = 0;
  logic i_req = 0, i_req_ext = 1, i_req_write = 0, i_external_wait_request_n;
  logic [23:0] i_req_addr = 0, o_addr;
  logic [15:0] i_req_wdata = 0, o_data_out, wdata;
  logic o_req_ready, o_done, o_remap_active, o_boot_8bit, o_data_oe;
  logic [31:0] o_ram_base;
  logic [7:0] o_chip_select_n;
  logic o_read_strobe_n, o_lower_byte_write_strobe_n;
  logic o_upper_byte_write_strobe_n, o_lower_byte_select_n;
  logic o_upper_byte_select_n, clr = 0, chain = 0;
  logic [3:0] stall = 0;
  logic [4:0] seen;
  int wr_width, rd_phase, fails = 0, checks_done = 0, cycles = 0, lat, base;
  ebt_bus_engine dut (.*);
  ebt_mem_model mdl (.i_clk_sys(i_clk_sys), .i_clr(clr), .i_stall(stall),
    .i_cs_n(o_chip_select_n), .i_rd_n(o_read_strobe_n),
    .i_lw_n(o_lower_byte_write_strobe_n), .i_uw_n(o_upper_byte_write_strobe_n),
    .i_lb_n(o_lower_byte_select_n), .i_ub_n(o_upper_byte_select_n),
    .i_data(o_data_out), .i_oe(o_data_oe), .o_wait_n(i_external_wait_request_n),
    .o_seen(seen), .o_wdata(wdata), .o_wr_width(wr_width),
    .o_rd_phase(rd_phase));
  always #12.5 i_clk_sys = ~i_clk_sys;
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Hang guard, far above the fewer than two hundred cycles needed
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      print_verdict();
    end
  end
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cfg(logic [2:0] cs, logic wait_state_enable_field, logic [2:0] wait_state_count_field,
                     logic [2:0] data_float_time_field, logic byte_access_type_field, logic [1:0] dbw);
    @(posedge i_clk_sys) #2;
    {i_cfg_sel, i_wait_state_enable_field, i_wait_state_count_field} =
      {cs, wait_state_enable_field, wait_state_count_field};
    {i_data_float_time_field, i_byte_access_type_field, i_cfg_dbw} =
      {data_float_time_field, byte_access_type_field, dbw};
    i_cfg_we = 1'h1;
    @(posedge i_clk_sys) #2 i_cfg_we = 1'h0;
  endtask
  // Latency in lat: edges from the taking edge until done is seen
  task automatic acc(logic wr, logic [2:0] cs, logic [1:0] be);
    int n;
    n = 0;
    @(posedge i_clk_sys) #2;
    {i_req, i_req_write, i_req_cs, i_req_byte_en} = {1'h1, wr, cs, be};
    i_req_addr = {cs, 21'h0_0010};
    i_req_wdata = {5'h00, cs, 8'h5a};
    clr = 1'h1;
    while (o_req_ready !== 1'h1 && n < 50) begin
      @(posedge i_clk_sys) #2;
      n++;
    end
    @(posedge i_clk_sys) #2;
    i_req = 1'h0;
    clr = 1'h0;
    lat = 0;
    while (o_done !== 1'h1 && lat < 50) begin
      @(posedge i_clk_sys) #2;
      lat++;
    end
    // Next read already pending in the end cycle
    if (chain) i_req = 1'h1;
  endtask
  task automatic t_boot();
    check("remap", 1, o_remap_active);
    check("ram_base", 32'h0030_0000, o_ram_base);
    check("boot_8bit", 1, o_boot_8bit);
    check("idle_cs", 8'hff, o_chip_select_n);
    $display("t_boot done");
  endtask
  task automatic t_waits();
    for (int n = 0; n < 9; n++) begin
      cfg(3'h0, n < 8, 3'(7 - n), 3'h0, 1'h0, 2'h2);
      acc(1'h1, 3'h0, 2'h1);
      check("wr_width", n < 8 ? (8 - n) * 250 : 125, wr_width);
      check("wr_data", 16'h005a, wdata);
    end
    @(posedge i_clk_sys) #2 i_remap_cancel_bit = 1'h1;
    @(posedge i_clk_sys) #2 i_remap_cancel_bit = 1'h0;
    repeat (3) @(posedge i_clk_sys);
    check("remap_off", 0, o_remap_active);
    $display("t_waits done");
  endtask
  task automatic t_bytes();
    cfg(3'h1, 1'h0, 3'h0, 3'h0, 1'h0, 2'h1);
    acc(1'h1, 3'h1, 2'h2);
    check("bw_wr", 3'h1, seen[4:2]);
    acc(1'h0, 3'h1, 2'h3);
    check("bw_rd", 3'h4, seen[4:2]);
    cfg(3'h1, 1'h0, 3'h0, 3'h0, 1'h1, 2'h1);
    acc(1'h1, 3'h1, 2'h1);
    check("bs_wr", 5'h0a, seen);
    acc(1'h0, 3'h1, 2'h2);
    check("bs_rd", 5'h11, seen);
    $display("t_bytes done");
  endtask
  task automatic t_proto();
    acc(1'h0, 3'h1, 2'h3);
    base = lat;
    check("std_phase", 0, rd_phase);
    acc(1'h1, 3'h1, 2'h3);
    acc(1'h0, 3'h1, 2'h3);
    check("std_wr_rd", base, lat);
    i_read_protocol_field = 1'h1;
    acc(1'h1, 3'h1, 2'h3);
    chain = 1'h1;
    acc(1'h0, 3'h1, 2'h3);
    chain = 1'h0;
    check("er_wr_rd", base + 1, lat);
    check("er_phase", 125, rd_phase);
    acc(1'h0, 3'h1, 2'h3);
    check("er_rd_rd", base, lat);
    check("er_held", 0, seen[4]);
    acc(1'h1, 3'h1, 2'h3);
    check("er_rd_wr", base, lat);
    i_read_protocol_field = 1'h0;
    $display("t_proto done");
  endtask
  task automatic t_float();
    cfg(3'h3, 1'h0, 3'h0, 3'h3, 1'h1, 2'h1);
    cfg(3'h4, 1'h0, 3'h0, 3'h0, 1'h1, 2'h1);
    acc(1'h0, 3'h3, 2'h3);
    acc(1'h0, 3'h3, 2'h3);
    check("same_cs", base, lat);
    acc(1'h0, 3'h4, 2'h3);
    check("float", base + 3, lat);
    acc(1'h0, 3'h3, 2'h3);
    check("cs_change", base + 1, lat);
    {i_req, i_req_ext} = 2'h2;
    repeat (6) @(posedge i_clk_sys);
    #2 check("internal", 0, o_done);
    {i_req, i_req_ext} = 2'h1;
    acc(1'h0, 3'h4, 2'h3);
    check("float_idle", base + 1, lat);
    $display("t_float done");
  endtask
  task automatic t_stall();
    acc(1'h0, 3'h1, 2'h3);
    stall = 4'h3;
    acc(1'h0, 3'h1, 2'h3);
    stall = 4'h0;
    check("ext_wait", base + 3, lat);
    i_boot_memory_pin = 1'h0;
    @(posedge i_clk_sys) #2 i_resetn = 1'h0;
    repeat (2) @(posedge i_clk_sys);
    #2 i_resetn = 1'h1;
    check("boot_kept", 1, o_boot_8bit);
    check("reboot", 1, o_remap_active);
    $display("t_stall done");
  endtask
  initial begin
    repeat (2) @(posedge i_clk_sys);
    #2;
    i_resetn = 1'h1;
    i_pin_reset_n = 1'h1;
    t_boot();
    t_waits();
    t_bytes();
    t_proto();
    t_float();
    t_stall();
    print_verdict();
  end
endmodule // ebt_bus_engine_test
`default_nettype wire
